// >>> design/vic_pkg.sv
/*
  Constants and types for the vectored interrupt control block.
  Assumes a processor sequencer that reports instruction boundaries and a register file port.
*/
`default_nettype none
package vic_pkg;
  localparam int NUM_SRC = 5;
  // Source index, highest priority first
  localparam int SRC_PIN = 0;
  localparam int SRC_TM0 = 1;
  localparam int SRC_TM1 = 2;
  localparam int SRC_BTM = 3;
  localparam int SRC_SIO = 4;
  // Register file addresses (7-bit)
  localparam logic [6:0] ADDR_SIO_EN = 7'h2e;
  localparam logic [6:0] ADDR_PIN_TM_EN = 7'h2f;
  localparam logic [6:0] ADDR_SIO_REQ = 7'h3b;
  localparam logic [6:0] ADDR_BTM_REQ = 7'h3c;
  localparam logic [6:0] ADDR_TM1_REQ = 7'h3d;
  localparam logic [6:0] ADDR_TM0_REQ = 7'h3e;
  localparam logic [6:0] ADDR_PIN_REQ = 7'h3f;
  localparam logic [6:0] ADDR_EDGE_SEL = 7'h1f;
  localparam logic [3:0] FLAG_RESET = 4'h0;
  // Vectors
  localparam logic [11:0] VEC_PIN = 12'h005;
  localparam logic [11:0] VEC_TM0 = 12'h004;
  localparam logic [11:0] VEC_TM1 = 12'h003;
  localparam logic [11:0] VEC_BTM = 12'h002;
  localparam logic [11:0] VEC_SIO = 12'h001;
  // Instruction cycles that acceptance waits after a delaying instruction
  localparam logic [1:0] DELAY_NORMAL = 2'h1;
  localparam logic [1:0] DELAY_LONG = 2'h2;
  localparam int PC_W = 12;
  localparam int CTX_W = 8;
  // Instruction boundary report from the sequencer
  typedef struct packed {
    logic done;       // Instruction cycle ends this clock
    logic table_move_instruction;       // Two-cycle table move in progress
    logic ei;         // Enable instruction
    logic di;         // Disable instruction
    logic return_from_irq_instruction;       // Return from interrupt
    logic skip;       // Skip condition met
    logic stop;       // Clock-stopping standby executed
  } vic_instr_t;
  // Register file access
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [3:0] wdata;
  } vic_rf_t;
  typedef struct packed {
    logic tm0_match;
    logic tm1_match;
    logic btm_ovf;
    logic sio_end;
    logic tm0_res;
    logic tm1_res;
    logic btm_res;
  } vic_evt_t;
endpackage
`default_nettype wire

// >>> design/vic_edge.sv
/*
  Pin edge detector for the external request.
  Assumes an asynchronous pin; it is synchronised here before use.
*/
`default_nettype none
module vic_edge (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // Pin and select
  input wire logic pin,
  input wire logic [1:0] edge_sel,
  output logic hit
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic rise;
  logic fall;
  // ===========================================
  // Synchroniser plus one history stage
  always_comb begin
    sh_d = {sh_q[1:0], pin};
  end
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sh_q <= 3'h0;
    end else if (ce) begin
      sh_q <= sh_d;
    end
  end
  // Only the second and third stages feed the compare
  assign rise = sh_q[1] & ~sh_q[2];
  assign fall = ~sh_q[1] & sh_q[2];
  // Bit0 rising, bit1 falling; both set gives either edge
  assign hit = ce & ((edge_sel[0] & rise) | (edge_sel[1] & fall));
endmodule
`default_nettype wire

// >>> design/vic_top.sv
/*
  Vectored interrupt control: request and enable flags, global enable,
  priority, acceptance timing and context stacks.
  Assumes the sequencer pulses instr.done at each instruction cycle end and
  jumps to irq_vector when irq_take pulses, treating that cycle as the INT cycle.
*/
`default_nettype none
module vic_top #(
  parameter int STACK_DEPTH = 3
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // Register file port
  input wire vic_pkg::vic_rf_t rf,
  output logic [3:0] rf_rdata,
  output logic rf_hit,
  // Sequencer
  input wire vic_pkg::vic_instr_t instr,
  input wire logic [vic_pkg::PC_W-1:0] ret_pc,
  input wire logic [vic_pkg::CTX_W-1:0] ctx_in,
  output logic irq_take,
  output logic [vic_pkg::PC_W-1:0] irq_vector,
  output logic [vic_pkg::PC_W-1:0] pop_pc,
  output logic [vic_pkg::CTX_W-1:0] pop_ctx,
  output logic [1:0] level,
  // Peripheral events and pin
  input wire vic_pkg::vic_evt_t evt,
  input wire logic ext_pin
);
  localparam int N = vic_pkg::NUM_SRC;
  logic [N-1:0] req_q, req_d, en_q, en_d, set_ev, wr_hit;
  logic [1:0] edge_sel_q, edge_sel_d;
  logic gie_q, gie_d, ei_pend_q, ei_pend_d;
  logic [1:0] wait_q, wait_d;
  logic pin_hit, take;
  logic [N-1:0] elig;
  logic [2:0] win;
  logic [1:0] sp_q, sp_d;
  logic [vic_pkg::PC_W-1:0] pc_stk_q [STACK_DEPTH];
  logic [vic_pkg::CTX_W-1:0] ctx_stk_q [STACK_DEPTH];
  logic [vic_pkg::PC_W-1:0] vec_q, vec_d;

  // ===========================================
  // Pin edge detector
  vic_edge u_edge (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .pin(ext_pin),
    .edge_sel(edge_sel_q),
    .hit(pin_hit)
  );

  // ===========================================
  // Request address decode, one bit per source
  always_comb begin
    wr_hit = '0;
    if (rf.wr) begin
      wr_hit[vic_pkg::SRC_PIN] = rf.addr == vic_pkg::ADDR_PIN_REQ;
      wr_hit[vic_pkg::SRC_TM0] = rf.addr == vic_pkg::ADDR_TM0_REQ;
      wr_hit[vic_pkg::SRC_TM1] = rf.addr == vic_pkg::ADDR_TM1_REQ;
      wr_hit[vic_pkg::SRC_BTM] = rf.addr == vic_pkg::ADDR_BTM_REQ;
      wr_hit[vic_pkg::SRC_SIO] = rf.addr == vic_pkg::ADDR_SIO_REQ;
    end
  end
  // Hardware set events per source
  assign set_ev[vic_pkg::SRC_PIN] = pin_hit;
  assign set_ev[vic_pkg::SRC_TM0] = evt.tm0_match;
  assign set_ev[vic_pkg::SRC_TM1] = evt.tm1_match;
  assign set_ev[vic_pkg::SRC_BTM] = evt.btm_ovf;
  assign set_ev[vic_pkg::SRC_SIO] = evt.sio_end;

  // ===========================================
  // Priority: lowest index wins among enabled pending sources
  assign elig = req_q & en_q;
  always_comb begin
    win = 3'h7;
    for (int i = N - 1; i >= 0; i--) begin
      if (elig[i]) begin
        win = 3'(i);
      end
    end
  end
  // Accept only at an instruction boundary once the wait has run out.
  // The next wait value is used so that a delaying instruction blocks its own
  // boundary; the boundary after it then admits the request.
  assign take = ce & instr.done & gie_q & (|elig) & (wait_d == vic_pkg::DELAY_NORMAL)
    & (sp_q < 2'(STACK_DEPTH));

  // ===========================================
  // Request flags: hardware set wins over every clear
  generate
    for (genvar s = 0; s < N; s++) begin : g_req
      always_comb begin
        req_d[s] = req_q[s];
        if (wr_hit[s]) begin
          req_d[s] = rf.wdata[0];
        end
        if (take && win == 3'(s)) begin
          req_d[s] = 1'b0;
        end
        if (s == vic_pkg::SRC_TM0 && evt.tm0_res) begin
          req_d[s] = 1'b0;
        end
        if (s == vic_pkg::SRC_TM1 && (evt.tm1_res || instr.stop)) begin
          req_d[s] = 1'b0;
        end
        if (s == vic_pkg::SRC_BTM && evt.btm_res) begin
          req_d[s] = 1'b0;
        end
        if (set_ev[s]) begin
          req_d[s] = 1'b1;
        end
      end
    end
  endgenerate

  // ===========================================
  // Enable flags and edge select
  always_comb begin
    en_d = en_q;
    edge_sel_d = edge_sel_q;
    if (rf.wr && rf.addr == vic_pkg::ADDR_PIN_TM_EN) begin
      en_d[vic_pkg::SRC_BTM:vic_pkg::SRC_PIN] = rf.wdata;
    end
    if (rf.wr && rf.addr == vic_pkg::ADDR_SIO_EN) begin
      en_d[vic_pkg::SRC_SIO] = rf.wdata[0];
    end
    if (rf.wr && rf.addr == vic_pkg::ADDR_EDGE_SEL) begin
      edge_sel_d = rf.wdata[1:0];
    end
  end

  // ===========================================
  // Global enable with one-instruction delay after enable instruction
  always_comb begin
    gie_d = gie_q;
    ei_pend_d = ei_pend_q;
    if (instr.done) begin
      if (ei_pend_q) begin
        gie_d = 1'b1;
        ei_pend_d = 1'b0;
      end
      if (instr.ei) begin
        ei_pend_d = 1'b1;
      end
      if (instr.di) begin
        gie_d = 1'b0;
        ei_pend_d = 1'b0;
      end
    end
    if (take) begin
      gie_d = 1'b0;
    end
  end

  // ===========================================
  // Acceptance wait: a delaying instruction pushes service one cycle further
  always_comb begin
    wait_d = wait_q;
    if (instr.done) begin
      if (instr.table_move_instruction || instr.ei || instr.skip) begin
        wait_d = vic_pkg::DELAY_LONG;
      end else if (wait_q != vic_pkg::DELAY_NORMAL) begin
        wait_d = wait_q - 2'h1;
      end
    end
  end

  // ===========================================
  // Vector select and stack pointer
  always_comb begin
    unique case (win)
      3'h0: vec_d = vic_pkg::VEC_PIN;
      3'h1: vec_d = vic_pkg::VEC_TM0;
      3'h2: vec_d = vic_pkg::VEC_TM1;
      3'h3: vec_d = vic_pkg::VEC_BTM;
      3'h4: vec_d = vic_pkg::VEC_SIO;
      default: vec_d = vec_q;
    endcase
    sp_d = sp_q;
    if (take) begin
      sp_d = sp_q + 2'h1;
    end else if (ce && instr.done && instr.return_from_irq_instruction && sp_q != 2'h0) begin
      sp_d = sp_q - 2'h1;
    end
  end

  // ===========================================
  // Registers; everything holds while ce is low
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      req_q <= '0;
      en_q <= '0;
      edge_sel_q <= 2'h0;
      gie_q <= 1'b0;
      ei_pend_q <= 1'b0;
      wait_q <= vic_pkg::DELAY_NORMAL;
      sp_q <= 2'h0;
      vec_q <= '0;
    end else if (ce) begin
      req_q <= req_d;
      en_q <= en_d;
      edge_sel_q <= edge_sel_d;
      gie_q <= gie_d;
      ei_pend_q <= ei_pend_d;
      wait_q <= wait_d;
      sp_q <= sp_d;
      if (take) begin
        vec_q <= vec_d;
      end
    end
  end

  // ===========================================
  // Context stacks, written at the free level on acceptance
  generate
    for (genvar k = 0; k < STACK_DEPTH; k++) begin : g_stk
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          pc_stk_q[k] <= '0;
          ctx_stk_q[k] <= '0;
        end else if (take && sp_q == 2'(k)) begin
          pc_stk_q[k] <= ret_pc;
          ctx_stk_q[k] <= ctx_in;
        end
      end
    end
  endgenerate

  // ===========================================
  // Outputs; global enable is deliberately absent from the read map
  always_comb begin
    rf_hit = 1'b1;
    rf_rdata = 4'h0;
    unique case (rf.addr)
      vic_pkg::ADDR_PIN_REQ: rf_rdata = {3'h0, req_q[vic_pkg::SRC_PIN]};
      vic_pkg::ADDR_TM0_REQ: rf_rdata = {3'h0, req_q[vic_pkg::SRC_TM0]};
      vic_pkg::ADDR_TM1_REQ: rf_rdata = {3'h0, req_q[vic_pkg::SRC_TM1]};
      vic_pkg::ADDR_BTM_REQ: rf_rdata = {3'h0, req_q[vic_pkg::SRC_BTM]};
      vic_pkg::ADDR_SIO_REQ: rf_rdata = {3'h0, req_q[vic_pkg::SRC_SIO]};
      vic_pkg::ADDR_PIN_TM_EN: rf_rdata = en_q[vic_pkg::SRC_BTM:vic_pkg::SRC_PIN];
      vic_pkg::ADDR_SIO_EN: rf_rdata = {3'h0, en_q[vic_pkg::SRC_SIO]};
      vic_pkg::ADDR_EDGE_SEL: rf_rdata = {2'h0, edge_sel_q};
      default: rf_hit = 1'b0;
    endcase
  end
  assign irq_take = take;
  assign irq_vector = vec_d;
  assign level = sp_q;
  // Pop reads the top level; empty stack returns level 0 contents
  assign pop_pc = pc_stk_q[(sp_q == 2'h0) ? 0 : int'(sp_q) - 1];
  assign pop_ctx = ctx_stk_q[(sp_q == 2'h0) ? 0 : int'(sp_q) - 1];
endmodule
`default_nettype wire

// >>> sim/vic_asserts.sv
/*
  Port checker for the interrupt control top.
  Assumes vic_top ports as declared; attached by the bind at the foot.
*/
`default_nettype none
module vic_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // Sequencer side
  input wire vic_pkg::vic_instr_t instr,
  input wire logic [11:0] ret_pc,
  input wire logic [7:0] ctx_in,
  input wire logic irq_take,
  input wire logic [11:0] irq_vector,
  input wire logic [11:0] pop_pc,
  input wire logic [7:0] pop_ctx,
  input wire logic [1:0] level
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====================
  // Boundaries since the last enable; the enable's own boundary must not admit
  logic [1:0] arm_q;
  logic [1:0] arm_d;
  always_comb begin
    arm_d = arm_q;
    if (ce && instr.done && arm_q != 2'h0 && arm_q != 2'h3) arm_d = arm_q + 2'h1;
    if (ce && instr.done && (instr.di || irq_take)) arm_d = 2'h0;
    if (ce && instr.done && instr.ei) arm_d = 2'h1;
  end
  always_ff @(posedge mclk) begin
    if (!nrst) arm_q <= 2'h0;
    else arm_q <= arm_d;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ====================
  // Acceptance
  take_on_done_a: assert property (irq_take |-> ce && instr.done)
    else $error("accept off an instruction boundary");
  vec_known_a: assert property (irq_take |-> irq_vector inside {[12'h001:12'h005]})
    else $error("vector outside the table");
  gie_arm_a: assert property (irq_take |-> arm_q >= 2'h2)
    else $error("accept without a settled enable");
  level_push_a: assert property (irq_take |=> level == $past(level) + 2'h1)
    else $error("level not pushed");
  ctx_push_a: assert property (irq_take |=> pop_pc == $past(ret_pc) && pop_ctx == $past(ctx_in))
    else $error("context not saved");
  level_cap_a: assert property (irq_take |-> level != 2'h3)
    else $error("accept with stack full");
  return_from_irq_instruction_pop_a: assert property (ce && instr.done && instr.return_from_irq_instruction && !irq_take && level != 2'h0
    |=> level == $past(level) - 2'h1)
    else $error("return did not pop");
  reset_clear_a: assert property ($rose(nrst) |-> level == 2'h0 && !irq_take)
    else $error("state not clear after reset");
  cover property (irq_take && irq_vector == vic_pkg::VEC_SIO);
  cover property (ce && instr.done && instr.table_move_instruction);
  cover property (ce && instr.done && instr.return_from_irq_instruction && level == 2'h1);
endmodule
bind vic_top vic_chk u_chk (.mclk(mclk), .nrst(nrst), .ce(ce), .instr(instr), .ret_pc(ret_pc),
  .ctx_in(ctx_in), .irq_take(irq_take), .irq_vector(irq_vector), .pop_pc(pop_pc),
  .pop_ctx(pop_ctx), .level(level));
`default_nettype wire

// >>> sim/vic_seq.sv
/*
  Sequencer model: instruction boundaries, kinds and return addresses.
  Assumes the bench commands each instruction kind through op.
*/
`default_nettype none
module vic_seq (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Commanded kind and interrupt side
  input wire vic_pkg::vic_instr_t op,
  input wire logic irq_take,
  input wire logic [11:0] irq_vector,
  input wire logic [11:0] pop_pc,
  output vic_pkg::vic_instr_t instr,
  output logic [11:0] ret_pc,
  output logic [7:0] ctx_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] ph_q;
  logic [11:0] pc_q;
  // Four clocks an instruction, shortened to keep the run brief
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ph_q <= 2'h0;
      pc_q <= 12'h000;
    end else begin
      ph_q <= ph_q + 2'h1;
      if (instr.done) pc_q <= irq_take ? irq_vector : op.return_from_irq_instruction ? pop_pc : pc_q + 12'h001;
    end
  end
  // Qualifiers ride only on the boundary clock
  always_comb begin
    instr = op;
    instr.done = (ph_q == 2'h3);
    if (!instr.done) instr = '0;
  end
  assign ret_pc = pc_q + 12'h001;
  assign ctx_in = pc_q[7:0] ^ 8'h5a;
endmodule
`default_nettype wire

// >>> sim/test_vectored_interrupt_control.sv
/*
  Self-checking bench for the interrupt control block.
  Assumes vic_top, the sequencer model and the bound checker.
*/
`default_nettype none
module test_vectored_interrupt_control;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    vic_pkg::vic_evt_t e;
    logic w;
    logic [6:0] a;
    logic [3:0] d;
    logic [3:0] x;
  } vic_row_t;
  localparam logic [6:0] NOP = 7'h00, TABLE_MOVE_INSTRUCTION = 7'h20, EI = 7'h10, DI = 7'h08;
  localparam logic [6:0] RETURN_FROM_IRQ_INSTRUCTION = 7'h04, SKIP = 7'h02, STOP = 7'h01;
  logic mclk, nrst, ce, rf_hit, irq_take, ext_pin, t;
  vic_pkg::vic_rf_t rf;
  vic_pkg::vic_instr_t op, instr;
  vic_pkg::vic_evt_t evt;
  logic [3:0] rf_rdata;
  logic [1:0] level;
  logic [11:0] ret_pc, irq_vector, pop_pc, vec;
  logic [7:0] ctx_in, pop_ctx;
  int n_mismatch, checked;
  vic_row_t rows [13];
  logic [6:0] regs [7] = '{7'h2e, 7'h2f, 7'h3b, 7'h3c, 7'h3d, 7'h3e, 7'h3f};
  vic_top #(.STACK_DEPTH(3)) dut (.mclk(mclk), .nrst(nrst), .ce(ce), .rf(rf),
    .rf_rdata(rf_rdata), .rf_hit(rf_hit), .instr(instr), .ret_pc(ret_pc), .ctx_in(ctx_in),
    .irq_take(irq_take), .irq_vector(irq_vector), .pop_pc(pop_pc), .pop_ctx(pop_ctx),
    .level(level), .evt(evt), .ext_pin(ext_pin));
  vic_seq seq (.mclk(mclk), .nrst(nrst), .op(op), .irq_take(irq_take),
    .irq_vector(irq_vector), .pop_pc(pop_pc), .instr(instr), .ret_pc(ret_pc), .ctx_in(ctx_in));
  always #4 mclk = ~mclk;
  // ====================
  // Tasks; a write leaves its strobe up so back-to-back writes never double-drive it
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [3:0] d);
    rf = {1'b1, a, d};
    @(posedge mclk);
    #1;
  endtask
  task automatic rd(input logic [6:0] a, input logic [3:0] x);
    rf = {1'b0, a, 4'h0};
    #1 chk({8'h00, rf_rdata}, {8'h00, x});
  endtask
  task automatic step(input logic [6:0] k);
    rf.wr = 1'b0;
    op = k;
    @(negedge mclk);
    for (int j = 0; j < 8 && instr.done !== 1'b1; j++) @(negedge mclk);
    t = irq_take;
    vec = irq_vector;
    @(posedge mclk);
    #1 op = NOP;
    @(posedge mclk);
    #1;
  endtask
  task automatic take_until;
    for (int j = 0; j < 4 && t !== 1'b1; j++) step(NOP);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run of a few hundred clocks
  initial begin
    #160000;
    n_mismatch++;
    close_out();
  end
  // Event or write, then the flag read back
  initial rows = '{
    {7'h00, 1'b1, 7'h3e, 4'h1, 4'h1}, {7'h00, 1'b1, 7'h3e, 4'h0, 4'h0},
    {7'h40, 1'b0, 7'h3e, 4'h0, 4'h1}, {7'h04, 1'b0, 7'h3e, 4'h0, 4'h0},
    {7'h20, 1'b0, 7'h3d, 4'h0, 4'h1}, {7'h02, 1'b0, 7'h3d, 4'h0, 4'h0},
    {7'h10, 1'b0, 7'h3c, 4'h0, 4'h1}, {7'h01, 1'b0, 7'h3c, 4'h0, 4'h0},
    {7'h08, 1'b0, 7'h3b, 4'h0, 4'h1}, {7'h00, 1'b1, 7'h3b, 4'h0, 4'h0},
    {7'h00, 1'b1, 7'h3f, 4'h1, 4'h1}, {7'h00, 1'b1, 7'h2f, 4'hf, 4'hf},
    {7'h00, 1'b1, 7'h3d, 4'h1, 4'h1}};
  // ====================
  // Main sequence
  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    ce = 1'b1;
    rf = '0;
    op = '0;
    evt = '0;
    ext_pin = 1'b0;
    n_mismatch = 0;
    checked = 0;
    repeat (2) @(posedge mclk);
    #1 nrst = 1'b1;
    foreach (regs[i]) rd(regs[i], 4'h0);
    chk({11'h000, rf_hit}, 12'h001);
    rf.addr = 7'h10;
    #1 chk({7'h00, rf_hit, rf_rdata}, 12'h000);
    foreach (rows[i]) begin
      evt = rows[i].e;
      rf = {rows[i].w, rows[i].a, rows[i].d};
      @(posedge mclk);
      #1 evt = '0;
      rd(rows[i].a, rows[i].x);
    end
    step(STOP);
    rd(7'h3d, 4'h0);
    wr(7'h2e, 4'h1);
    for (int v = 1; v <= 5; v++) wr(7'h3a + 7'(v), 4'h1);
    // All five pending: served highest first, each needing a fresh enable
    for (int i = 0; i < 5; i++) begin
      step(EI);
      step(NOP);
      chk({11'h000, t}, 12'h000);
      take_until();
      chk(vec, 12'(5 - i));
      chk({10'h000, level}, 12'h001);
      rd(7'h3f - 7'(i), 4'h0);
      if (i < 4) rd(7'h3e - 7'(i), 4'h1);
      step(RETURN_FROM_IRQ_INSTRUCTION);
      chk({10'h000, level}, 12'h000);
    end
    wr(7'h2f, 4'h0);
    wr(7'h3e, 4'h1);
    step(EI);
    repeat (3) step(NOP);
    chk({11'h000, t}, 12'h000);
    rd(7'h3e, 4'h1);
    step(DI);
    wr(7'h2f, 4'h2);
    repeat (3) step(NOP);
    chk({11'h000, t}, 12'h000);
    step(EI);
    take_until();
    chk({11'h000, t}, 12'h001);
    step(RETURN_FROM_IRQ_INSTRUCTION);
    wr(7'h3e, 4'h1);
    repeat (3) step(NOP);
    chk({11'h000, t}, 12'h000);
    // Delaying kinds: a pending request waits past their boundary
    for (int i = 0; i < 2; i++) begin
      wr(7'h3e, 4'h0);
      step(EI);
      repeat (2) step(NOP);
      wr(7'h3e, 4'h1);
      step(i == 0 ? TABLE_MOVE_INSTRUCTION : SKIP);
      chk({11'h000, t}, 12'h000);
      take_until();
      chk({11'h000, t}, 12'h001);
      step(RETURN_FROM_IRQ_INSTRUCTION);
    end
    // Pin edges: rising, then falling
    for (int i = 0; i < 2; i++) begin
      wr(7'h1f, 4'(i + 1));
      wr(7'h3f, 4'h0);
      rf.wr = 1'b0;
      ext_pin = ~ext_pin;
      repeat (4) @(posedge mclk);
      #1 rd(7'h3f, 4'h1);
    end
    close_out();
  end
endmodule
`default_nettype wire
